// ===== brs_top.sv
`timescale 1ns/1ps
`default_nettype none
module brs_top #(
   parameter int unsigned POR_CYC = brs_pkg::POR_HOLD_CYC
) (
   // clock and reset
   input  wire logic        pclk,
   input  wire logic        presetn,
   // apb slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   // pins from the board
   input  wire logic        supply_ok,
   input  wire logic        por_button_n,
   input  wire logic        soft_reset_button_n,
   input  wire logic        abort_button_n,
   input  wire logic [2:0]  clock_mode_select,
   input  wire logic [3:0]  high_clock_mode_bits,
   input  wire logic        pci_clock_halve_select,
   input  wire logic        config_master_select_n,
   input  wire logic        scan_hard_reset_line_n_force,
   // internal reset sources
   input  wire logic        pll_core_unlock,
   input  wire logic        pll_comm_unlock,
   input  wire logic        checkstop,
   input  wire logic        bus_cycle_timeout,
   input  wire logic        watchdog_expired,
   // open-drain reset lines
   input  wire logic        hard_reset_line_in,
   output logic             hard_reset_line_oe,
   output logic             soft_reset_line_oe,
   input  wire logic        soft_reset_line_in,
   // outputs to the processor
   output logic             power_on_reset_n,
   output logic             internal_reset_n,
   output logic             refresh_reset_n,
   output logic             reset_vector_go,
   output logic [2:0]       clock_mode_ff,
   output logic [3:0]       upper_clock_mode_field,
   output logic             pci_halve_ff,
   // boot device byte reads
   output logic             boot_rd,
   output logic [8:0]       boot_addr,
   input  wire logic [7:0]  boot_data,
   input  wire logic        boot_ack
);
   typedef enum logic [2:0] {BRS_POR, BRS_HEXT, BRS_HWAIT, BRS_HCHK, BRS_CFG, BRS_SEXT, BRS_RUN} brs_state_t;
   brs_state_t state_ff, nxt_state;

   // three-stage synchronisers, change counts when stages 2 and 3 agree
   localparam int NSYNC = 9;
   logic [NSYNC-1:0] raw_in;
   logic [NSYNC-1:0] s1_ff, s2_ff, s3_ff, clean_ff;
   assign raw_in = {supply_ok, por_button_n, soft_reset_button_n, abort_button_n, config_master_select_n,
                    hard_reset_line_in, scan_hard_reset_line_n_force, pll_core_unlock, pll_comm_unlock};
   genvar gi;
   generate
      for (gi = 0; gi < NSYNC; gi++) begin : g_sync
         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               s1_ff[gi]    <= 1'b0;
               s2_ff[gi]    <= 1'b0;
               s3_ff[gi]    <= 1'b0;
               clean_ff[gi] <= 1'b0;
            end else begin
               s1_ff[gi] <= raw_in[gi];
               s2_ff[gi] <= s1_ff[gi];
               s3_ff[gi] <= s2_ff[gi];
               if (s2_ff[gi] == s3_ff[gi]) begin
                  clean_ff[gi] <= s3_ff[gi];
               end
            end
         end
      end
   endgenerate
   wire supply_ok_s   = clean_ff[8];
   wire por_btn_n_s   = clean_ff[7];
   wire sbtn_n_s      = clean_ff[6];
   wire abtn_n_s      = clean_ff[5];
   wire cfg_master_s  = ~clean_ff[4];
   wire hline_low_s   = ~clean_ff[3];
   wire scan_force_s  = clean_ff[2];
   wire unlock_s      = clean_ff[1] | clean_ff[0];

   // register file
   logic [3:0]  ctrl_ff;
   logic [31:0] cfg_word_ff;
   logic        first_hard_reset_line_n_ff;
   logic        cfg_master_ff;
   wire wr_en   = psel & penable & pwrite;
   wire hit_ctl = (paddr == brs_pkg::REG_CTRL);
   wire hit_sts = (paddr == brs_pkg::REG_STATUS);
   wire hit_cfg = (paddr == brs_pkg::REG_CFG_WORD);
   wire hit_clk = (paddr == brs_pkg::REG_CLOCK);
   wire hit_any = hit_ctl | hit_sts | hit_cfg | hit_clk;
   wire checkstop_reset_enable    = ctrl_ff[brs_pkg::CTRL_CHECKSTOP_RESET_ENABLE_BIT];
   wire sw_por  = ctrl_ff[brs_pkg::CTRL_SW_POR_BIT];
   wire bmon_en = ctrl_ff[brs_pkg::CTRL_BMON_EN_BIT];
   wire wdog_en = ctrl_ff[brs_pkg::CTRL_WDOG_EN_BIT];
   wire [31:0] status_word = {25'h0, first_hard_reset_line_n_ff, cfg_master_ff, hline_low_s, 1'b0, state_ff};
   wire [31:0] clock_word  = {24'h0, pci_halve_ff, upper_clock_mode_field, clock_mode_ff};
   wire [31:0] rd_mux = hit_ctl ? {28'h0, ctrl_ff} :
                        hit_sts ? status_word :
                        hit_cfg ? cfg_word_ff :
                        hit_clk ? clock_word : brs_pkg::RD_ZERO;
   assign pready  = 1'b1;
   assign pslverr = psel & penable & ~hit_any;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= brs_pkg::RD_ZERO;
      end else if (psel & ~penable & ~pwrite) begin
         prdata <= rd_mux;
      end
   end

   // power-on request sources
   wire por_req = ~supply_ok_s | ~por_btn_n_s | sw_por;

   // hard-reset sources
   wire manual_hard = ~sbtn_n_s & ~abtn_n_s;
   wire int_hard    = unlock_s
                    | (checkstop & checkstop_reset_enable)
                    | (bus_cycle_timeout & bmon_en)
                    | (watchdog_expired & wdog_en)
                    | scan_force_s;
   // debug controller and board pull the line; seen here as line low
   wire hard_req    = int_hard | manual_hard | hline_low_s;

   // counters
   // one counter serves every timed phase (POR, HEXT, HWAIT, SEXT; CFG counts bytes in byte_ff), so it is sized for the longest one
   localparam int unsigned CSEQ = (brs_pkg::HRST_EXT_CYC > brs_pkg::SRST_EXT_CYC) ? brs_pkg::HRST_EXT_CYC
                                                                                  : brs_pkg::SRST_EXT_CYC;
   localparam int unsigned CMAX = (POR_CYC > CSEQ) ? POR_CYC : CSEQ;
   localparam int CW = $clog2(CMAX + 1);
   logic [CW-1:0] cnt_ff, nxt_cnt;
   logic [5:0]    byte_ff, nxt_byte;
   logic          rd_pend_ff;
   wire [CW-1:0] por_last  = CW'(POR_CYC - 1);
   wire [CW-1:0] hext_last = CW'(brs_pkg::HRST_EXT_CYC - 1);
   wire [CW-1:0] hwt_last  = CW'(brs_pkg::HRST_WAIT_CYC - 1);
   wire [CW-1:0] sext_last = CW'(brs_pkg::SRST_EXT_CYC - 1);
   wire boot_take = boot_ack & rd_pend_ff;
   wire cfg_done  = boot_take & (byte_ff == 6'(brs_pkg::CFG_BYTES - 1));
   wire cfg_take  = boot_take & (state_ff == BRS_CFG) & (byte_ff < 6'h04);

   always_comb begin
      nxt_state = state_ff;
      nxt_cnt   = cnt_ff + CW'(1);
      nxt_byte  = byte_ff;
      unique case (state_ff)
         BRS_POR: begin
            if (por_req) begin
               nxt_cnt = '0;
            end else if (cnt_ff == por_last) begin
               nxt_state = BRS_HEXT;
               nxt_cnt   = '0;
            end
         end
         BRS_HEXT: begin
            if (cnt_ff == hext_last) begin
               nxt_state = BRS_HWAIT;
               nxt_cnt   = '0;
            end
         end
         BRS_HWAIT: begin
            if (cnt_ff == hwt_last) begin
               nxt_state = BRS_HCHK;
            end
         end
         BRS_HCHK: begin
            nxt_cnt = '0;
            if (hline_low_s | int_hard | manual_hard) begin
               nxt_state = BRS_HEXT;
            end else if (cfg_master_ff) begin
               nxt_state = BRS_CFG;
               nxt_byte  = '0;
            end else begin
               nxt_state = BRS_SEXT;
            end
         end
         BRS_CFG: begin
            nxt_cnt = '0;
            if (boot_ack & rd_pend_ff) begin
               nxt_byte = byte_ff + 6'h01;
            end
            if (cfg_done) begin
               nxt_state = BRS_SEXT;
            end
         end
         BRS_SEXT: begin
            if (cnt_ff == sext_last) begin
               nxt_state = BRS_RUN;
            end
         end
         BRS_RUN: begin
            nxt_cnt = '0;
            if (hard_req) begin
               nxt_state = BRS_HEXT;
            end
         end
      endcase
      if (por_req && state_ff != BRS_POR) begin
         nxt_state = BRS_POR;
         nxt_cnt   = '0;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_ff <= BRS_POR;
         cnt_ff   <= '0;
         byte_ff  <= '0;
      end else begin
         state_ff <= nxt_state;
         cnt_ff   <= nxt_cnt;
         byte_ff  <= nxt_byte;
      end
   end

   // boot reads: one byte per request, address stride of eight
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rd_pend_ff <= 1'b0;
      end else begin
         rd_pend_ff <= (state_ff == BRS_CFG) & ~cfg_done;
      end
   end
   assign boot_rd   = rd_pend_ff;
   assign boot_addr = {byte_ff, 3'b000};

   // first word assembled msb first; later words are for absent chips
   wire in_hard   = (state_ff == BRS_HEXT) | (state_ff == BRS_HWAIT) | (state_ff == BRS_HCHK);
   wire por_end   = (state_ff == BRS_POR) & (nxt_state == BRS_HEXT);
   wire take_high = (state_ff == BRS_HWAIT) & (cnt_ff == hwt_last);
   wire cfg_start = (state_ff == BRS_HCHK) & (nxt_state != BRS_HEXT);
   // software power-on request clears itself once the sequencer sits in POR
   wire ctrl_clr  = in_hard | (state_ff == BRS_POR);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_ff                <= brs_pkg::CTRL_RESET;
         clock_mode_ff          <= 3'h0;
         upper_clock_mode_field <= 4'h0;
         pci_halve_ff           <= 1'b0;
         first_hard_reset_line_n_ff        <= 1'b0;
      end else begin
         if (wr_en & hit_ctl) begin
            ctrl_ff <= pwdata[3:0];
         end else if (ctrl_clr) begin
            ctrl_ff <= brs_pkg::CTRL_RESET;
         end
         if (por_end) begin
            clock_mode_ff   <= clock_mode_select;
            first_hard_reset_line_n_ff <= 1'b1;
         end
         if (take_high) begin
            if (first_hard_reset_line_n_ff) begin
               upper_clock_mode_field <= high_clock_mode_bits;
               pci_halve_ff           <= pci_clock_halve_select;
            end
            first_hard_reset_line_n_ff <= 1'b0;
         end
      end
   end

   // config word: default unless read from the boot device as master
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cfg_word_ff <= brs_pkg::DEFAULT_CFG_WORD;
      end else if (cfg_start) begin
         cfg_word_ff <= brs_pkg::DEFAULT_CFG_WORD;
      end else if (cfg_take) begin
         cfg_word_ff <= {cfg_word_ff[23:0], boot_data};
      end
   end

   // latched at the rising edge of power-on reset, decides master role
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cfg_master_ff <= 1'b0;
      end else if (por_end) begin
         cfg_master_ff <= cfg_master_s;
      end
   end

   // reset outputs
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         power_on_reset_n   <= 1'b0;
         hard_reset_line_oe <= 1'b0;
         soft_reset_line_oe <= 1'b0;
         internal_reset_n   <= 1'b0;
         refresh_reset_n    <= 1'b0;
         reset_vector_go    <= 1'b0;
      end else begin
         power_on_reset_n   <= (nxt_state != BRS_POR);
         hard_reset_line_oe <= (nxt_state == BRS_HEXT);
         soft_reset_line_oe <= (nxt_state == BRS_SEXT);
         internal_reset_n   <= (nxt_state == BRS_RUN);
         refresh_reset_n    <= ~((nxt_state == BRS_POR) | (nxt_state == BRS_HEXT));
         reset_vector_go    <= (state_ff == BRS_SEXT) & (nxt_state == BRS_RUN);
      end
   end

   wire unused_ok = soft_reset_line_in;
endmodule
`default_nettype wire

// ===== brs_pkg.sv
package brs_pkg;
   // pclk is 10 MHz
   localparam int unsigned CLK_PERIOD_NS    = 100;
   // power-on reset hold, in milliseconds (~2.5 s)
   localparam int unsigned POR_HOLD_MS      = 2500;
   localparam int unsigned POR_HOLD_CYC     = (POR_HOLD_MS * 1000000) / CLK_PERIOD_NS;
   localparam int unsigned HRST_EXT_CYC     = 512;
   localparam int unsigned HRST_WAIT_CYC    = 16;
   localparam int unsigned SRST_EXT_CYC     = 512;
   localparam int unsigned CFG_BYTES        = 64;
   localparam int unsigned CFG_ADDR_STEP    = 8;
   // register map (byte addresses)
   localparam logic [11:0] REG_CTRL         = 12'h000;
   localparam logic [11:0] REG_STATUS       = 12'h004;
   localparam logic [11:0] REG_CFG_WORD     = 12'h008;
   localparam logic [11:0] REG_CLOCK        = 12'h00C;
   localparam logic [11:0] REG_BOOT_DATA    = 12'h010;
   // control fields
   localparam int unsigned CTRL_CHECKSTOP_RESET_ENABLE_BIT    = 0;
   localparam int unsigned CTRL_SW_POR_BIT  = 1;
   localparam int unsigned CTRL_BMON_EN_BIT = 2;
   localparam int unsigned CTRL_WDOG_EN_BIT = 3;
   localparam logic [3:0]  CTRL_RESET       = 4'h0;
   localparam logic [31:0] DEFAULT_CFG_WORD = 32'h0000_0000;
   localparam logic [31:0] RD_ZERO          = 32'h0000_0000;
endpackage

// ===== brs_top_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module brs_top_assertions #(
   parameter int unsigned POR_CYC = 20
) (
   // clock and reset
   input wire logic       pclk,
   input wire logic       presetn,
   // reset lines and status
   input wire logic       hard_reset_line_oe,
   input wire logic       soft_reset_line_oe,
   input wire logic       power_on_reset_n,
   input wire logic       internal_reset_n,
   input wire logic       reset_vector_go,
   input wire logic       refresh_reset_n,
   // boot reads
   input wire logic       boot_rd,
   input wire logic [8:0] boot_addr,
   input wire logic       boot_ack
);
   logic [31:0] hcnt_ff;
   logic [31:0] scnt_ff;
   logic [31:0] pcnt_ff;
   // length of the current pull or low phase
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         hcnt_ff <= 32'h0;
         scnt_ff <= 32'h0;
         pcnt_ff <= 32'h0;
      end else begin
         hcnt_ff <= hard_reset_line_oe ? hcnt_ff + 32'h1 : 32'h0;
         scnt_ff <= soft_reset_line_oe ? scnt_ff + 32'h1 : 32'h0;
         pcnt_ff <= power_on_reset_n ? 32'h0 : pcnt_ff + 32'h1;
      end
   end
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   sequence s_hext_done;
      $fell(hard_reset_line_oe);
   endsequence
   sequence s_hwait;
      !hard_reset_line_oe [*8];
   endsequence
   a_hext_len: assert property (s_hext_done |-> hcnt_ff == 32'h200)
      else $error("hard line pull length wrong");
   a_hwait_gap: assert property (s_hext_done |-> s_hwait)
      else $error("hard line pulled again too soon");
   a_sext_len: assert property ($fell(soft_reset_line_oe) |-> scnt_ff == 32'h200)
      else $error("soft line pull length wrong");
   a_por_hold: assert property ($rose(power_on_reset_n) |-> pcnt_ff >= POR_CYC)
      else $error("power-on reset released early");
   a_por_hext: assert property ($rose(power_on_reset_n) |-> ##[0:4] hard_reset_line_oe)
      else $error("no hard reset after power-on");
   a_soft_vec: assert property ($fell(soft_reset_line_oe) |-> ##[0:4] reset_vector_go)
      else $error("no vector start after soft phase");
   a_run_quiet: assert property (internal_reset_n |-> power_on_reset_n && !hard_reset_line_oe)
      else $error("running while reset active");
   a_boot_step: assert property (boot_rd && boot_ack |=> !boot_rd || boot_addr == $past(boot_addr) + 9'h008)
      else $error("boot address not on stride");
   a_boot_first: assert property ($rose(boot_rd) |-> boot_addr == 9'h000)
      else $error("boot reads do not start at zero");
   a_refresh_hard: assert property (hard_reset_line_oe || !power_on_reset_n |-> !refresh_reset_n)
      else $error("refresh logic not reset");
   a_boot_hold: assert property (boot_rd && !boot_ack |=> boot_rd && $stable(boot_addr))
      else $error("boot request dropped early");
endmodule
bind brs_top brs_top_assertions #(.POR_CYC(POR_CYC)) u_brs_top_assertions (
   .pclk, .presetn, .hard_reset_line_oe, .soft_reset_line_oe, .power_on_reset_n,
   .internal_reset_n, .reset_vector_go, .refresh_reset_n, .boot_rd, .boot_addr, .boot_ack);
`default_nettype wire

// ===== brs_board_model.sv
`timescale 1ns/1ps
`default_nettype none
module brs_board_model (
   // clock and reset
   input wire logic        pclk,
   input wire logic        presetn,
   // boot device
   input wire logic        boot_rd,
   input wire logic [8:0]  boot_addr,
   output logic [7:0]      boot_data,
   output logic            boot_ack,
   output int              n_reads,
   // debug controller
   input wire logic        dbg_pull_req,
   output logic            hard_reset_line_n_pull
);
   logic [1:0] wait_ff;
   // only ever pulls the line low, never drives it high
   assign hard_reset_line_n_pull = dbg_pull_req;
   // every other read answers slowly; released bus shows inverted data
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         boot_ack <= 1'b0;
         boot_data <= 8'h55;
         wait_ff <= 2'h0;
         n_reads <= 0;
      end else if (boot_rd && !boot_ack) begin
         if (wait_ff == (n_reads[0] ? 2'h3 : 2'h0)) begin
            boot_ack <= 1'b1;
            boot_data <= {2'h2, boot_addr[8:3]};
            n_reads <= n_reads + 1;
            wait_ff <= 2'h0;
         end else begin
            wait_ff <= wait_ff + 2'h1;
         end
      end else begin
         boot_ack <= 1'b0;
         boot_data <= ~boot_data;
      end
   end
endmodule
`default_nettype wire

// ===== brs_top_tb.sv
`timescale 1ns/1ps
`default_nettype none
module brs_top_tb;
   logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic        supply_ok = 1'b0, por_n = 1'b1, sbtn_n = 1'b1, abtn_n = 1'b1, cfgm_n = 1'b0;
   logic        pci_h = 1'b1, dbg = 1'b0, err, hoe_q = 1'b0;
   logic [2:0]  mode = 3'h5, clock_mode_ff;
   logic [3:0]  high = 4'hA, upper_clock_mode_field;
   logic [5:0]  src = 6'h00;
   logic        pready, pslverr, hard_reset_line_oe, soft_reset_line_oe, power_on_reset_n;
   logic        internal_reset_n, reset_vector_go, pci_halve_ff, boot_rd, boot_ack, hard_reset_line_n_pull;
   logic [8:0]  boot_addr;
   logic [7:0]  boot_data;
   int          n_errors = 0, compares = 0, cyc = 0, n_hrise = 0, n_reads;
   localparam logic [3:0] CT [9] = '{4'h0, 4'h0, 4'h1, 4'h0, 4'h4, 4'h0, 4'h8, 4'h0, 4'h0};
   localparam logic [5:0] SM [9] = '{6'h01, 6'h02, 6'h04, 6'h04, 6'h08, 6'h08, 6'h10, 6'h10, 6'h20};
   localparam logic [8:0] EX = 9'h157;
   always #50 pclk = ~pclk;
   brs_top #(.POR_CYC(20)) u_brs_top (
      .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
      .supply_ok, .por_button_n(por_n), .soft_reset_button_n(sbtn_n), .abort_button_n(abtn_n),
      .clock_mode_select(mode), .high_clock_mode_bits(high), .pci_clock_halve_select(pci_h),
      .config_master_select_n(cfgm_n), .scan_hard_reset_line_n_force(src[5]), .pll_core_unlock(src[0]),
      .pll_comm_unlock(src[1]), .checkstop(src[2]), .bus_cycle_timeout(src[3]),
      .watchdog_expired(src[4]), .hard_reset_line_in(!(hard_reset_line_oe || hard_reset_line_n_pull)),
      .hard_reset_line_oe, .soft_reset_line_oe, .soft_reset_line_in(!soft_reset_line_oe),
      .power_on_reset_n, .internal_reset_n, .refresh_reset_n(), .reset_vector_go, .clock_mode_ff,
      .upper_clock_mode_field, .pci_halve_ff, .boot_rd, .boot_addr, .boot_data, .boot_ack);
   brs_board_model u_brs_board_model (.pclk, .presetn, .boot_rd, .boot_addr, .boot_data,
      .boot_ack, .n_reads, .dbg_pull_req(dbg), .hard_reset_line_n_pull);
   always @(negedge pclk) begin
      if (hard_reset_line_oe && !hoe_q) n_hrise++;
      hoe_q = hard_reset_line_oe;
      cyc++;
      if (cyc == 60000) begin
         n_errors++;
         finish_test();
      end
   end
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         n_errors++;
         $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
      end
   endtask
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wait_run(input int pre);
      repeat (pre) @(negedge pclk);
      while (internal_reset_n !== 1'b1) @(negedge pclk);
   endtask
   task automatic t_power_up;
      @(posedge pclk) supply_ok <= 1'b1;
      wait_run(1);
      check(clock_mode_ff, 3'h5);
      check(upper_clock_mode_field, 4'hA);
      check(pci_halve_ff, 1'b1);
      check(n_reads, 32'h40);
      check(n_hrise, 32'h1);
      apb(1'b0, brs_pkg::REG_CFG_WORD, 32'h0);
      check(rd, 32'h80818283);
      apb(1'b0, brs_pkg::REG_STATUS, 32'h0);
      check(rd[5:0], 6'h26);
   endtask
   task automatic t_apb;
      apb(1'b1, brs_pkg::REG_CTRL, 32'hD);
      apb(1'b0, brs_pkg::REG_CTRL, 32'h0);
      check(rd[3:0], 4'hD);
      apb(1'b0, 12'h020, 32'h0);
      check(err, 1'b1);
      check(rd, brs_pkg::RD_ZERO);
   endtask
   task automatic t_buttons;
      @(posedge pclk);
      mode <= 3'h2; high <= 4'h3; sbtn_n <= 1'b0;
      repeat (30) @(posedge pclk);
      sbtn_n <= 1'b1; abtn_n <= 1'b0;
      repeat (30) @(posedge pclk);
      abtn_n <= 1'b1;
      wait_run(20);
      check(n_hrise, 32'h1);
      @(posedge pclk) sbtn_n <= 1'b0; abtn_n <= 1'b0;
      repeat (10) @(posedge pclk);
      sbtn_n <= 1'b1; abtn_n <= 1'b1;
      wait_run(20);
      check(n_hrise, 32'h2);
      check(clock_mode_ff, 3'h5);
      check(upper_clock_mode_field, 4'hA);
      apb(1'b0, brs_pkg::REG_CTRL, 32'h0);
      check(rd[3:0], 4'h0);
   endtask
   task automatic t_sources;
      int h;
      for (int i = 0; i < 9; i++) begin
         h = n_hrise;
         apb(1'b1, brs_pkg::REG_CTRL, {28'h0, CT[i]});
         @(posedge pclk) src <= SM[i];
         repeat (10) @(posedge pclk);
         src <= 6'h00;
         wait_run(20);
         check(n_hrise, h + EX[i]);
      end
   endtask
   task automatic t_debug;
      int h;
      h = n_hrise;
      @(posedge pclk) dbg <= 1'b1;
      repeat (700) @(posedge pclk);
      dbg <= 1'b0;
      wait_run(20);
      check(n_hrise, h + 2);
   endtask
   task automatic t_por;
      int r;
      r = n_reads;
      @(posedge pclk) cfgm_n <= 1'b1; por_n <= 1'b0;
      repeat (10) @(posedge pclk);
      por_n <= 1'b1;
      repeat (10) @(negedge pclk);
      check(power_on_reset_n, 1'b0);
      wait_run(1);
      check(clock_mode_ff, 3'h2);
      check(upper_clock_mode_field, 4'h3);
      check(n_reads, r);
      apb(1'b0, brs_pkg::REG_CFG_WORD, 32'h0);
      check(rd, brs_pkg::DEFAULT_CFG_WORD);
      apb(1'b1, brs_pkg::REG_CTRL, 32'h2);
      repeat (5) @(negedge pclk);
      check(power_on_reset_n, 1'b0);
      wait_run(1);
   endtask
   task automatic finish_test;
      $display("errors %0d compares %0d", n_errors, compares);
      if (n_errors == 0 && compares > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   initial begin
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      t_power_up();
      t_apb();
      t_buttons();
      t_sources();
      t_debug();
      t_por();
      finish_test();
   end
endmodule
`default_nettype wire
